//--- rtl/led_i2c_device.sv
// led driver end: serial target, fixed registers, page select
// link logic runs on scl; register results cross to clock_i by toggle
`timescale 1ns/1ps
module led_i2c_device (
    // link
    led_i2c_link_if.device link,
    // power-up reset and system clock
    input wire logic rst_n_i,
    input wire logic clock_i,
    // strap and status from the chip
    input wire led_i2c_pkg::strap_type strap_i,
    input wire logic [1:0] int_status_i,
    // register results, clock_i domain
    output logic [7:0] page_select_o,
    output logic [7:0] int_mask_o,
    output logic paged_wr_o,
    output logic [7:0] paged_wr_page_o,
    output logic [7:0] paged_wr_addr_o,
    output logic [7:0] paged_wr_data_o
);
    // ----------------------------------------------------------
    // types and state
    // ----------------------------------------------------------
    typedef enum logic [3:0] {
        S_IDLE,
        S_ADDR,
        S_ADDR_ACK,
        S_REG,
        S_REG_ACK,
        S_WDATA,
        S_WDATA_ACK,
        S_RDATA,
        S_RDATA_ACK
    } link_state_type;

    link_state_type state; // state after last scl rise
    link_state_type cur; // state this rise acts in
    link_state_type next_state;
    logic [2:0] bit_cnt; // bits taken in the current byte
    logic [7:0] shift; // received bits
    logic [7:0] tx; // byte being returned
    logic rw; // direction of this transfer
    logic [7:0] ptr; // register pointer
    logic [7:0] page_select; // current page
    logic [7:0] int_mask; // interrupt enable mask
    logic [7:0] unlock; // page select unlock register
    logic wr_toggle; // flips on every register write
    logic [7:0] wr_addr; // last write address
    logic [7:0] wr_data; // last write data
    logic [7:0] wr_page; // page at last write
    logic wr_paged; // last write went to a page
    logic sda_rise; // sda seen at last scl rise
    logic start_seen; // start caught on last scl fall
    logic drive_low; // device pulls sda
    logic [1:0] strap_s1, strap_s2; // strap synchroniser
    logic [1:0] status_s1, status_s2; // status synchroniser
    logic [2:0] tog_sync; // write toggle into clock_i

    // ----------------------------------------------------------
    // helper decoding
    // ----------------------------------------------------------
    // strap net to address bits
    function automatic logic [1:0] strap_bits(input logic [1:0] s);
        case (s)
            led_i2c_pkg::STRAP_SUPPLY: strap_bits = led_i2c_pkg::ADDR_BITS_SUPPLY;
            led_i2c_pkg::STRAP_SCL: strap_bits = led_i2c_pkg::ADDR_BITS_SCL;
            led_i2c_pkg::STRAP_SDA: strap_bits = led_i2c_pkg::ADDR_BITS_SDA;
            default: strap_bits = led_i2c_pkg::ADDR_BITS_GROUND;
        endcase
    endfunction

    // fixed registers stand outside every page
    function automatic logic is_fixed(input logic [7:0] a);
        is_fixed = (a == led_i2c_pkg::REG_INTERRUPT_ENABLE_MASK)
                || (a == led_i2c_pkg::REG_INTERRUPT_STATUS)
                || (a == led_i2c_pkg::REG_IDENTIFICATION)
                || (a == led_i2c_pkg::REG_PAGE_SELECT)
                || (a == led_i2c_pkg::REG_PAGE_SELECT_UNLOCK);
    endfunction

    // read value; write-only and paged locations give zero
    function automatic logic [7:0] read_value(input logic [7:0] a, input logic [7:0] lk,
                                               input logic [1:0] st, input logic [7:0] id);
        case (a)
            led_i2c_pkg::REG_INTERRUPT_STATUS: read_value = {6'h00, st};
            led_i2c_pkg::REG_IDENTIFICATION: read_value = id;
            led_i2c_pkg::REG_PAGE_SELECT_UNLOCK: read_value = lk;
            default: read_value = led_i2c_pkg::READ_NONE;
        endcase
    endfunction

    wire [6:0] own_addr = {led_i2c_pkg::ADDR_FIXED_CODE, strap_bits(strap_s2)};
    wire [7:0] ident = {own_addr, led_i2c_pkg::DIR_WRITE};
    wire [2:0] cnt_now = start_seen ? 3'h0 : bit_cnt;
    wire byte_done = (cnt_now == led_i2c_pkg::BIT_LAST);
    wire [7:0] rx_byte = {shift[6:0], link.sda};
    wire addr_match = (rx_byte[7:1] == own_addr);
    wire [7:0] ptr_plus = ptr + 8'h01;
    wire receiving = (cur == S_ADDR) || (cur == S_REG) || (cur == S_WDATA);
    wire counting = receiving || (cur == S_RDATA);
    wire reg_done = (cur == S_REG) && byte_done;
    wire wr_commit = (cur == S_WDATA_ACK);
    wire rd_load = (cur == S_ADDR_ACK) && (rw == led_i2c_pkg::DIR_READ);
    wire rd_next = (cur == S_RDATA_ACK) && (link.sda == led_i2c_pkg::ACK_LEVEL);
    wire wr_page_sel = wr_commit && (ptr == led_i2c_pkg::REG_PAGE_SELECT);
    wire page_ok = (unlock == led_i2c_pkg::PAGE_SELECT_UNLOCK_CODE)
                && (shift <= led_i2c_pkg::FUNCTION_PAGE);
    wire page_take = wr_page_sel && page_ok;
    wire start_cond = sda_rise && !link.sda; // sda fell while scl high
    wire ack_state = (state == S_ADDR_ACK) || (state == S_REG_ACK) || (state == S_WDATA_ACK);
    wire next_drive_low = ack_state || ((state == S_RDATA) && !tx[7]);

    // ----------------------------------------------------------
    // byte sequencing
    // ----------------------------------------------------------
    // a start forces the address phase whatever went before
    always_comb begin
        cur = start_seen ? S_ADDR : state;
        case (cur)
            S_ADDR: next_state = byte_done ? (addr_match ? S_ADDR_ACK : S_IDLE) : S_ADDR;
            S_ADDR_ACK: next_state = (rw == led_i2c_pkg::DIR_READ) ? S_RDATA : S_REG;
            S_REG: next_state = byte_done ? S_REG_ACK : S_REG;
            S_REG_ACK: next_state = S_WDATA;
            S_WDATA: next_state = byte_done ? S_WDATA_ACK : S_WDATA;
            S_WDATA_ACK: next_state = S_WDATA;
            S_RDATA: next_state = byte_done ? S_RDATA_ACK : S_RDATA;
            S_RDATA_ACK: next_state = rd_next ? S_RDATA : S_IDLE; // nack ends the read
            default: next_state = S_IDLE;
        endcase
    end

    // ----------------------------------------------------------
    // rising scl: sample, count, commit
    // ----------------------------------------------------------
    // bit engine; reset is the power-up reset
    always_ff @(posedge link.scl or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state <= S_IDLE;
            bit_cnt <= 3'h0;
            shift <= 8'h00;
            rw <= led_i2c_pkg::DIR_WRITE;
            sda_rise <= 1'b0;
        end else begin
            state <= next_state;
            bit_cnt <= counting ? cnt_now + 3'h1 : 3'h0;
            sda_rise <= link.sda;
            if (receiving) begin
                shift <= rx_byte;
            end
            if ((cur == S_ADDR) && byte_done) begin
                rw <= rx_byte[0];
            end
        end
    end

    // pointer and returned byte
    always_ff @(posedge link.scl or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ptr <= 8'h00;
            tx <= 8'h00;
        end else begin
            if (reg_done) begin
                ptr <= rx_byte;
            end else if (wr_commit || rd_next) begin
                ptr <= ptr_plus;
            end
            if (rd_load) begin
                tx <= read_value(ptr, unlock, status_s2, ident);
            end else if (rd_next) begin
                tx <= read_value(ptr_plus, unlock, status_s2, ident);
            end else if (cur == S_RDATA) begin
                tx <= {tx[6:0], 1'b0};
            end
        end
    end

    // fixed registers; writes commit during the data acknowledge
    always_ff @(posedge link.scl or negedge rst_n_i) begin
        if (!rst_n_i) begin
            page_select <= led_i2c_pkg::FIRST_PWM_PAGE;
            int_mask <= led_i2c_pkg::MASK_RESET;
            unlock <= led_i2c_pkg::UNLOCK_RESET;
        end else begin
            if (page_take) begin
                page_select <= shift;
                unlock <= led_i2c_pkg::UNLOCK_RESET;
            end else if (wr_commit && (ptr == led_i2c_pkg::REG_PAGE_SELECT_UNLOCK)) begin
                unlock <= shift;
            end
            if (wr_commit && (ptr == led_i2c_pkg::REG_INTERRUPT_ENABLE_MASK)) begin
                int_mask <= shift;
            end
        end
    end

    // last write payload, held until the next write
    always_ff @(posedge link.scl or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wr_toggle <= 1'b0;
            wr_addr <= 8'h00;
            wr_data <= 8'h00;
            wr_page <= 8'h00;
            wr_paged <= 1'b0;
        end else if (wr_commit) begin
            wr_toggle <= !wr_toggle;
            wr_addr <= ptr;
            wr_data <= shift;
            wr_page <= page_select;
            wr_paged <= !is_fixed(ptr);
        end
    end

    // strap and status levels into the link domain
    always_ff @(posedge link.scl or negedge rst_n_i) begin
        if (!rst_n_i) begin
            strap_s1 <= 2'h0;
            strap_s2 <= 2'h0;
            status_s1 <= 2'h0;
            status_s2 <= 2'h0;
        end else begin
            strap_s1 <= strap_i;
            strap_s2 <= strap_s1;
            status_s1 <= int_status_i;
            status_s2 <= status_s1;
        end
    end

    // ----------------------------------------------------------
    // falling scl: start detect and sda drive
    // ----------------------------------------------------------
    // sda only changes while scl is low, so a change seen across
    // the high phase is a start or a stop; a stop needs no action
    // because the next start resets the byte engine anyway
    always_ff @(negedge link.scl or negedge rst_n_i) begin
        if (!rst_n_i) begin
            start_seen <= 1'b0;
            drive_low <= 1'b0;
        end else begin
            start_seen <= start_cond;
            drive_low <= start_cond ? 1'b0 : next_drive_low;
        end
    end

    assign link.sda_dev_o = 1'b0;
    assign link.sda_dev_oe_n = !drive_low;

    // ----------------------------------------------------------
    // crossing to clock_i
    // ----------------------------------------------------------
    // payload is stable for nine scl periods after each toggle,
    // far longer than the three clock_i edges the capture needs
    wire wr_event = tog_sync[1] ^ tog_sync[2];

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tog_sync <= 3'h0;
        end else begin
            tog_sync <= {tog_sync[1:0], wr_toggle};
        end
    end

    // captured results
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            page_select_o <= led_i2c_pkg::FIRST_PWM_PAGE;
            int_mask_o <= led_i2c_pkg::MASK_RESET;
            paged_wr_o <= 1'b0;
            paged_wr_page_o <= 8'h00;
            paged_wr_addr_o <= 8'h00;
            paged_wr_data_o <= 8'h00;
        end else begin
            paged_wr_o <= wr_event && wr_paged;
            if (wr_event) begin
                page_select_o <= page_select;
                int_mask_o <= int_mask;
                paged_wr_page_o <= wr_page;
                paged_wr_addr_o <= wr_addr;
                paged_wr_data_o <= wr_data;
            end
        end
    end

endmodule // led_i2c_device

//--- rtl/led_i2c_pkg.sv
// constants shared by both ends of the serial register link of the led matrix driver
// assumes a 50 MHz system clock; the link clock is made by the host end
package led_i2c_pkg;

    // ----------------------------------------------------------
    // target address
    // ----------------------------------------------------------
    localparam logic [4:0] ADDR_FIXED_CODE = 5'h15; // arbitrary value
    localparam logic [1:0] ADDR_BITS_GROUND = 2'h0;
    localparam logic [1:0] ADDR_BITS_SUPPLY = 2'h3;
    localparam logic [1:0] ADDR_BITS_SCL = 2'h1;
    localparam logic [1:0] ADDR_BITS_SDA = 2'h2;
    localparam logic DIR_WRITE = 1'h0; // direction_bit values
    localparam logic DIR_READ = 1'h1;
    localparam logic ACK_LEVEL = 1'h0;
    localparam logic [2:0] BIT_LAST = 3'h7;

    // which net the strap pin is tied to
    typedef enum logic [1:0] {
        STRAP_GROUND,
        STRAP_SUPPLY,
        STRAP_SCL,
        STRAP_SDA
    } strap_type;

    // ----------------------------------------------------------
    // register map and values
    // ----------------------------------------------------------
    localparam logic [7:0] REG_INTERRUPT_ENABLE_MASK = 8'hF0;
    localparam logic [7:0] REG_INTERRUPT_STATUS = 8'hF1;
    localparam logic [7:0] REG_IDENTIFICATION = 8'hFC;
    localparam logic [7:0] REG_PAGE_SELECT = 8'hFD;
    localparam logic [7:0] REG_PAGE_SELECT_UNLOCK = 8'hFE;
    localparam logic [7:0] PAGE_SELECT_UNLOCK_CODE = 8'hC5;
    localparam logic [7:0] UNLOCK_RESET = 8'h00;
    localparam logic [7:0] FIRST_PWM_PAGE = 8'h00;
    localparam logic [7:0] FUNCTION_PAGE = 8'h04;
    localparam logic [7:0] MASK_RESET = 8'h00;
    localparam logic [7:0] READ_NONE = 8'h00;

    // ----------------------------------------------------------
    // link timing
    // ----------------------------------------------------------
    localparam int CLOCK_NS = 20;
    localparam int SCL_MAX_KHZ = 1000;
    // one bit is four quarters; a quarter of the fastest bit
    localparam int QUARTER_NS = 1000000 / SCL_MAX_KHZ / 4;
    localparam int QUARTER_CYCLES = (QUARTER_NS + CLOCK_NS - 1) / CLOCK_NS;

    // host command kinds
    typedef enum logic [1:0] {
        CMD_START,
        CMD_WRITE,
        CMD_READ,
        CMD_STOP
    } cmd_type;

endpackage

//--- rtl/led_i2c_link_if.sv
// two-wire link between the host end and the led driver end
// scl is driven by the host only; sda is open drain with a pull-up
`timescale 1ns/1ps
interface led_i2c_link_if;
    logic scl; // link clock, host driven
    logic sda_dev_o; // device drive value
    logic sda_dev_oe_n; // device enable, low while driving
    logic sda_host_o; // host drive value
    logic sda_host_oe_n; // host enable, low while driving
    logic sda; // resolved wire

    // wired-and with pull-up: any enabled low drive wins
    assign sda = ((!sda_dev_oe_n && !sda_dev_o) || (!sda_host_oe_n && !sda_host_o)) ? 1'b0 : 1'b1;

    modport device (
        input scl,
        input sda,
        output sda_dev_o,
        output sda_dev_oe_n
    );
    modport host (
        output scl,
        input sda,
        output sda_host_o,
        output sda_host_oe_n
    );
endinterface // led_i2c_link_if

//--- rtl/led_i2c_host.sv
// host end: bus master making scl from clock_i, one command at a time
// assumes the user waits for cmd_ready_o before the next command
`timescale 1ns/1ps
module led_i2c_host #(
    parameter int QUARTER_CYCLES = led_i2c_pkg::QUARTER_CYCLES
) (
    // system
    input wire logic clock_i,
    input wire logic rst_n_i,
    // command
    input wire logic cmd_valid_i,
    output logic cmd_ready_o,
    input wire led_i2c_pkg::cmd_type cmd_kind_i,
    input wire logic [7:0] cmd_data_i,
    input wire logic cmd_nack_i,
    // answer
    output logic resp_valid_o,
    output logic [7:0] resp_data_o,
    output logic resp_nack_o,
    // link
    led_i2c_link_if.host link
);
    // ----------------------------------------------------------
    // elaboration check
    // ----------------------------------------------------------
    // the quarter timer is sixteen bits wide
    if (QUARTER_CYCLES < led_i2c_pkg::QUARTER_CYCLES || QUARTER_CYCLES > 65536) begin : g_too_fast
        $error("quarter outside the link clock limit or timer range");
    end

    // ----------------------------------------------------------
    // state
    // ----------------------------------------------------------
    logic [15:0] div; // quarter timer
    logic [1:0] q; // quarter within a symbol
    logic busy; // symbols remain
    led_i2c_pkg::cmd_type kind; // symbol kind in progress
    logic [3:0] left; // symbols left
    logic [8:0] tx; // bits to send, msb first, then ack
    logic [8:0] rx; // bits seen
    logic scl; // scl drive
    logic sda_low; // sda drive
    logic sda_s1, sda_s2; // sda synchroniser

    wire tick = busy && (div == 16'(QUARTER_CYCLES - 1));
    wire [1:0] q_next = q + 2'h1;
    wire [8:0] rx_next = {rx[7:0], sda_s2};
    wire is_byte = (kind == led_i2c_pkg::CMD_WRITE) || (kind == led_i2c_pkg::CMD_READ);
    wire last_sym = (left == 4'h1);
    wire auto_stop = (kind == led_i2c_pkg::CMD_WRITE) && rx_next[0];
    // level during the high phase and at its end: start falls, stop rises
    wire mid_level = (kind == led_i2c_pkg::CMD_START) ? 1'b1 :
                     (kind == led_i2c_pkg::CMD_STOP) ? 1'b0 : tx[8];
    wire end_level = (kind == led_i2c_pkg::CMD_START) ? 1'b0 :
                     (kind == led_i2c_pkg::CMD_STOP) ? 1'b1 : tx[8];
    wire next_sda_low = (q_next == 2'h3) ? !end_level : !mid_level;

    assign cmd_ready_o = !busy;
    assign link.scl = scl;
    assign link.sda_host_o = 1'b0;
    assign link.sda_host_oe_n = !sda_low;

    // sda pin into clock_i
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sda_s1 <= 1'b1;
            sda_s2 <= 1'b1;
        end else begin
            sda_s1 <= link.sda;
            sda_s2 <= sda_s1;
        end
    end

    // quarter timer
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            div <= 16'h0000;
        end else begin
            div <= (tick || !busy) ? 16'h0000 : div + 16'h0001;
        end
    end

    // ----------------------------------------------------------
    // symbol engine
    // ----------------------------------------------------------
    // a symbol: q0 scl low, q1 set sda, q2 scl high, q3 condition
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            busy <= 1'b0;
            kind <= led_i2c_pkg::CMD_STOP;
            left <= 4'h0;
            q <= 2'h3;
            tx <= 9'h1FF;
            rx <= 9'h000;
            scl <= 1'b1;
            sda_low <= 1'b0;
            resp_valid_o <= 1'b0;
            resp_data_o <= 8'h00;
            resp_nack_o <= 1'b0;
        end else begin
            resp_valid_o <= 1'b0;
            if (!busy && cmd_valid_i) begin
                busy <= 1'b1;
                kind <= cmd_kind_i;
                q <= 2'h0;
                scl <= 1'b0;
                left <= (cmd_kind_i == led_i2c_pkg::CMD_WRITE
                      || cmd_kind_i == led_i2c_pkg::CMD_READ) ? 4'h9 : 4'h1;
                tx <= (cmd_kind_i == led_i2c_pkg::CMD_WRITE) ? {cmd_data_i, 1'b1}
                                                             : {8'hFF, cmd_nack_i};
            end else if (tick && (q != 2'h3)) begin
                q <= q_next;
                scl <= q_next[1];
                sda_low <= next_sda_low;
            end else if (tick) begin
                rx <= rx_next; // sampled at the end of the high phase
                tx <= {tx[7:0], 1'b1};
                left <= left - 4'h1;
                q <= 2'h0;
                scl <= 1'b0;
                if (last_sym && is_byte) begin
                    resp_valid_o <= 1'b1;
                    resp_data_o <= rx_next[8:1];
                    resp_nack_o <= rx_next[0];
                end
                if (last_sym && is_byte && auto_stop) begin
                    kind <= led_i2c_pkg::CMD_STOP;
                    left <= 4'h1;
                end else if (last_sym) begin
                    busy <= 1'b0;
                    q <= 2'h3;
                    scl <= 1'b1; // stay in the high phase
                end
            end
        end
    end

endmodule // led_i2c_host

//--- tb/led_link_properties.sv
// property checker for the two-wire link of the led driver
// assumes scl comes from the host end, made from clock_i
`timescale 1ns/1ps
module led_link_checker (
    // system
    input wire logic clock_i,
    input wire logic rst_n_i,
    // link wires
    input wire logic scl,
    input wire logic sda,
    input wire logic sda_dev_o,
    input wire logic sda_dev_oe_n,
    input wire logic sda_host_oe_n
);
    // ------------------------------
    // wire rules on clock_i samples
    // ------------------------------
    default clocking @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);
    property p_idle; $rose(rst_n_i) |-> scl && sda; endproperty
    property p_steady; scl && $past(scl) && $changed(sda) |-> $changed(sda_host_oe_n); endproperty
    property p_ack_on; $fell(sda_dev_oe_n) |-> !scl; endproperty
    property p_ack_off; $rose(sda_dev_oe_n) |-> !scl; endproperty
    property p_ack_end; $fell(sda_dev_oe_n) |-> ##[1:600] sda_dev_oe_n; endproperty
    property p_dev_od; $changed(sda_dev_oe_n) |-> $fell(scl) && !sda_dev_o; endproperty
    property p_scl_low; $fell(scl) |=> !scl [*8]; endproperty
    property p_scl_high; $rose(scl) |=> scl [*8]; endproperty
    a_idle: assert property (p_idle) else $error("busy at reset release");
    a_steady: assert property (p_steady) else $error("sda moved, scl high");
    a_ack_on: assert property (p_ack_on) else $error("drive began, scl high");
    a_ack_off: assert property (p_ack_off) else $error("drive ended, scl high");
    a_ack_end: assert property (p_ack_end) else $error("drive too long");
    a_dev_od: assert property (p_dev_od) else $error("drive moved off scl fall");
    a_scl_low: assert property (p_scl_low) else $error("scl low too short");
    a_scl_high: assert property (p_scl_high) else $error("scl high too short");
    // main events: acknowledge, start, stop
    c_ack: cover property ($fell(sda_dev_oe_n));
    c_start: cover property (scl && $fell(sda));
    c_stop: cover property (scl && $rose(sda));
endmodule // led_link_checker

//--- tb/led_matrix_i2c_paged_access_test.sv
// bench: host end drives the led driver end over the link
// assumes the rtl files and the link checker are compiled first
`timescale 1ns/1ps
module led_matrix_i2c_paged_access_test;
    // ------------------------------
    // stimulus, results, instances
    // ------------------------------
    logic clock_i = 1'h0;
    logic rst_n_i = 1'h0;
    logic valid = 1'h0; // command strobe
    led_i2c_pkg::cmd_type kind = led_i2c_pkg::CMD_STOP;
    logic [7:0] data = 8'h00;
    logic nak = 1'h1; // ack bit the host gives on a read
    led_i2c_pkg::strap_type strap = led_i2c_pkg::STRAP_GROUND;
    logic [1:0] status = 2'h2; // short flag only
    logic [1:0] bits_of [4] = '{2'h0, 2'h3, 2'h1, 2'h2}; // strap to address bits
    wire [6:0] tgt = {led_i2c_pkg::ADDR_FIXED_CODE, bits_of[strap]};
    logic ready, rvalid, rnack, wstb;
    logic [7:0] rdata, page, mask, wpage, waddr, wdata;
    logic [23:0] seen [$]; // paged writes: page, address, data
    int n_mismatch = 0;
    int n_tests = 0;
    led_i2c_link_if link ();
    // a read answers ack or nack as the caller expects, so reads can run on
    led_i2c_host #(.QUARTER_CYCLES(13)) led_i2c_host_inst (.clock_i(clock_i), .rst_n_i(rst_n_i),
        .cmd_valid_i(valid), .cmd_ready_o(ready), .cmd_kind_i(kind), .cmd_data_i(data),
        .cmd_nack_i(nak), .resp_valid_o(rvalid), .resp_data_o(rdata), .resp_nack_o(rnack),
        .link(link.host));
    led_i2c_device led_i2c_device_inst (.link(link.device), .rst_n_i(rst_n_i), .clock_i(clock_i),
        .strap_i(strap), .int_status_i(status), .page_select_o(page), .int_mask_o(mask),
        .paged_wr_o(wstb), .paged_wr_page_o(wpage), .paged_wr_addr_o(waddr),
        .paged_wr_data_o(wdata));
    led_link_checker led_link_checker_inst (.clock_i(clock_i), .rst_n_i(rst_n_i),
        .scl(link.scl), .sda(link.sda), .sda_dev_o(link.sda_dev_o),
        .sda_dev_oe_n(link.sda_dev_oe_n), .sda_host_oe_n(link.sda_host_oe_n));
    // 50 MHz clock
    initial begin
        forever #10 clock_i = ~clock_i;
    end
    // hang guard, about twice the expected run
    initial begin
        repeat (90000) @(posedge clock_i);
        n_mismatch++;
        finish_test();
    end
    // paged write pulses last one cycle, so catch them here
    always @(posedge clock_i) begin
        if (wstb === 1'h1) seen.push_back({wpage, waddr, wdata});
    end
    task automatic chk(input string n, input logic [23:0] e, input logic [23:0] g);
        n_tests++;
        if (g !== e) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask
    // one command, held until taken; byte commands wait for the answer
    task automatic cmd(input led_i2c_pkg::cmd_type k, input logic [7:0] d, input logic nk);
        @(posedge clock_i);
        while (ready !== 1'h1) @(posedge clock_i);
        valid <= 1'h1;
        kind <= k;
        data <= d;
        nak <= nk;
        @(posedge clock_i);
        valid <= 1'h0;
        if (k == led_i2c_pkg::CMD_START || k == led_i2c_pkg::CMD_STOP) return;
        @(posedge clock_i);
        while (rvalid !== 1'h1) @(posedge clock_i);
        chk("ack", nk, rnack);
    endtask
    task automatic hdr(input logic [7:0] r);
        cmd(led_i2c_pkg::CMD_START, 8'h00, 1'h0);
        cmd(led_i2c_pkg::CMD_WRITE, {tgt, 1'h0}, 1'h0);
        cmd(led_i2c_pkg::CMD_WRITE, r, 1'h0);
    endtask
    task automatic wr(input logic [7:0] r, input logic [7:0] d, input int n);
        hdr(r);
        for (int i = 0; i < n; i++) cmd(led_i2c_pkg::CMD_WRITE, d + 8'(i), 1'h0);
        cmd(led_i2c_pkg::CMD_STOP, 8'h00, 1'h0);
    endtask
    task automatic rd(input logic [7:0] r, input logic [7:0] e);
        hdr(r);
        cmd(led_i2c_pkg::CMD_START, 8'h00, 1'h0);
        cmd(led_i2c_pkg::CMD_WRITE, {tgt, 1'h1}, 1'h0);
        cmd(led_i2c_pkg::CMD_READ, 8'h00, 1'h1);
        chk("read", e, rdata);
        cmd(led_i2c_pkg::CMD_STOP, 8'h00, 1'h0);
    endtask
    task automatic finish_test();
        if (n_mismatch == 0 && n_tests > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // main sequence
    initial begin
        repeat (12) @(posedge clock_i);
        rst_n_i <= 1'h1;
        chk("page", 8'h00, page);
        for (int s = 0; s < 4; s++) begin
            strap <= led_i2c_pkg::strap_type'(s);
            rd(8'hFC, {led_i2c_pkg::ADDR_FIXED_CODE, bits_of[s], 1'h0});
        end
        wr(8'hFD, 8'h02, 1);
        chk("page", 8'h00, page);
        wr(8'hFE, 8'hC5, 1);
        rd(8'hFE, 8'hC5);
        wr(8'hFD, 8'h05, 1);
        chk("page", 8'h00, page);
        for (int p = 4; p >= 0; p--) begin
            wr(8'hFE, 8'hC5, 1);
            wr(8'hFD, 8'(p), 1);
            chk("page", 8'(p), page);
        end
        rd(8'hFE, 8'h00);
        wr(8'hFD, 8'h03, 1);
        chk("page", 8'h00, page);
        wr(8'hFE, 8'hC5, 1);
        wr(8'hFD, 8'h03, 1);
        wr(8'h10, 8'hA0, 3);
        for (int i = 0; i < 3; i++)
            chk("paged", {8'h03, 8'(8'h10 + i), 8'(8'hA0 + i)}, seen[i]);
        rd(8'h10, led_i2c_pkg::READ_NONE);
        wr(8'hF0, 8'h13, 1);
        chk("mask", 8'h13, mask);
        rd(8'hF0, 8'h00);
        rd(8'hF1, {6'h00, status});
        // two bytes in one read: the pointer moves on after an acked byte
        hdr(8'hF0);
        cmd(led_i2c_pkg::CMD_START, 8'h00, 1'h0);
        cmd(led_i2c_pkg::CMD_WRITE, {tgt, 1'h1}, 1'h0);
        cmd(led_i2c_pkg::CMD_READ, 8'h00, 1'h0);
        chk("read", led_i2c_pkg::READ_NONE, rdata);
        cmd(led_i2c_pkg::CMD_READ, 8'h00, 1'h1);
        chk("read", {6'h00, status}, rdata);
        cmd(led_i2c_pkg::CMD_STOP, 8'h00, 1'h0);
        cmd(led_i2c_pkg::CMD_START, 8'h00, 1'h0);
        cmd(led_i2c_pkg::CMD_WRITE, {~tgt, 1'h0}, 1'h1);
        finish_test();
    end
endmodule // led_matrix_i2c_paged_access_test
